// >>> hw/rmdec_top.sv
// Remap window limit and low usable memory top decode block.
// Function
// - Limit register holds window top bits 35:26.
// - Window top low 26 bits are ones.
// - Limit below base disables the window.
// - Low top holds boundary bits 31:27.
// - Low top boundary bits 26:0 are zero.
// - Claim addresses strictly below low top.
// - Field zero or one means 128 MB.
// - Management segment reserved under low top.
// - Window base is inclusive, 64 MB aligned.
`default_nettype none
module rmdec_top (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire rmdec_pkg::rmdec_cfg_s   cfgReq,
  input  wire logic                    addrValid,
  input  wire logic [35:0]             hostAddr,
  input  wire logic                    segEnable,
  input  wire logic [1:0]              segSize,
  output logic [15:0]                  rdData_r,
  output logic                         rdValid_r,
  output logic                         decValid_r,
  output var rmdec_pkg::rmdec_hit_s    hit_r,
  output logic [15:0]                  remapLimitOut_r,
  output logic [7:0]                   lowTopOut_r
);
  // ==========================================================
  // Register storage.
  logic [15:0] remap_lower_bound_r;   // Lower bound register.
  logic [15:0] remap_window_upper_limit_r;  // Upper limit register.
  logic [7:0]  lowTop_r;      // Low usable memory top register.
  rmdec_pkg::rmdec_hit_s hitNxt; // Comparator result.
  logic        limLoHit;      // Access covers limit low byte.
  logic        limHiHit;      // Access covers limit high byte.
  logic        baseLoHit;     // Access covers base low byte.
  logic        baseHiHit;     // Access covers base high byte.
  logic        topHit;        // Access covers low top byte.

  // Byte lane decode of the 16-bit configuration port.
  always_comb begin
    limLoHit  = cfgReq.addr == rmdec_pkg::REMAP_LIMIT_OFFSET &&
                cfgReq.byteEn[0];
    limHiHit  = cfgReq.addr == rmdec_pkg::REMAP_LIMIT_OFFSET &&
                cfgReq.byteEn[1];
    baseLoHit = cfgReq.addr == rmdec_pkg::REMAP_BASE_OFFSET &&
                cfgReq.byteEn[0];
    baseHiHit = cfgReq.addr == rmdec_pkg::REMAP_BASE_OFFSET &&
                cfgReq.byteEn[1];
    topHit    = cfgReq.addr == rmdec_pkg::LOW_TOP_OFFSET &&
                cfgReq.byteEn[0];
  end

  // ==========================================================
  // Limit register writes.
  always_ff @(posedge clk) begin
    if (reset) begin
      remap_window_upper_limit_r <= rmdec_pkg::REMAP_LIMIT_RESET;
    end else if (cfgReq.wrEn) begin
      if (limLoHit) begin
        remap_window_upper_limit_r[7:0] <= cfgReq.wrData[7:0];
      end
      if (limHiHit) begin
        remap_window_upper_limit_r[15:8] <= cfgReq.wrData[15:8] &
                              rmdec_pkg::REMAP_WMASK[15:8];
      end
    end
  end

  // Base register writes; it feeds the window lower bound.
  always_ff @(posedge clk) begin
    if (reset) begin
      remap_lower_bound_r <= rmdec_pkg::REMAP_BASE_RESET;
    end else if (cfgReq.wrEn) begin
      if (baseLoHit) begin
        remap_lower_bound_r[7:0] <= cfgReq.wrData[7:0];
      end
      if (baseHiHit) begin
        remap_lower_bound_r[15:8] <= cfgReq.wrData[15:8] &
                             rmdec_pkg::REMAP_WMASK[15:8];
      end
    end
  end

  // Low top register writes.
  always_ff @(posedge clk) begin
    if (reset) begin
      lowTop_r <= rmdec_pkg::LOW_TOP_RESET;
    end else if (cfgReq.wrEn && topHit) begin
      lowTop_r <= cfgReq.wrData[7:0] & rmdec_pkg::LOW_TOP_WMASK;
    end
  end

  // ==========================================================
  // Read path: one cycle after the request; unmapped reads zero.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdData_r  <= 16'h0000;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= cfgReq.rdEn;
      if (cfgReq.rdEn) begin
        case (cfgReq.addr)
          rmdec_pkg::REMAP_LIMIT_OFFSET: rdData_r <= remap_window_upper_limit_r;
          rmdec_pkg::REMAP_BASE_OFFSET:  rdData_r <= remap_lower_bound_r;
          rmdec_pkg::LOW_TOP_OFFSET:     rdData_r <= {8'h00, lowTop_r};
          default:                       rdData_r <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Address comparison.
  rmdec_cmp uCmp (
    .hostAddr   (hostAddr),
    .remapLower (remap_lower_bound_r[9:0]),
    .remapUpper (remap_window_upper_limit_r[9:0]),
    .lowTop     (lowTop_r[7:3]),
    .segEnable  (segEnable),
    .segSize    (segSize),
    .hit        (hitNxt)
  );

  // Registered decode result, one cycle after the address.
  always_ff @(posedge clk) begin
    if (reset) begin
      hit_r      <= '0;
      decValid_r <= 1'b0;
    end else begin
      decValid_r <= addrValid;
      hit_r      <= addrValid ? hitNxt : '0;
    end
  end

  // Register mirrors for the rest of the controller.
  always_ff @(posedge clk) begin
    if (reset) begin
      remapLimitOut_r <= rmdec_pkg::REMAP_LIMIT_RESET;
      lowTopOut_r     <= rmdec_pkg::LOW_TOP_RESET;
    end else begin
      remapLimitOut_r <= remap_window_upper_limit_r;
      lowTopOut_r     <= lowTop_r;
    end
  end

  // ==========================================================
  // Checks of the decode behaviour.
  claim_low_a: assert property (@(posedge clk) disable iff (reset)
    addrValid && hostAddr[35:27] < {4'h0, lowTop_r[7:3]}
    |=> hit_r.claimLow)
    else $error("address below low top not claimed");
  claim_zero_a: assert property (@(posedge clk) disable iff (reset)
    addrValid && lowTop_r[7:3] == 5'h00 && hostAddr < 36'h008000000
    |=> hit_r.claimLow)
    else $error("zero low top is not 128 MB");
  window_off_a: assert property (@(posedge clk) disable iff (reset)
    remap_window_upper_limit_r[9:0] < remap_lower_bound_r[9:0] |=> !hit_r.inRemap)
    else $error("remap window active with limit below base");
  window_top_a: assert property (@(posedge clk) disable iff (reset)
    addrValid && remap_window_upper_limit_r[9:0] >= remap_lower_bound_r[9:0] &&
    hostAddr == {remap_window_upper_limit_r[9:0], 26'h3ffffff} |=> hit_r.inRemap)
    else $error("window top byte not inside window");
  window_base_a: assert property (@(posedge clk) disable iff (reset)
    addrValid && remap_window_upper_limit_r[9:0] >= remap_lower_bound_r[9:0] &&
    hostAddr == {remap_lower_bound_r[9:0], 26'h0000000} |=> hit_r.inRemap)
    else $error("window base not inside window");
  above_top_a: assert property (@(posedge clk) disable iff (reset)
    addrValid && hostAddr[35:27] >= {4'h0, lowTop_r[7:3]} &&
    lowTop_r[7:3] != 5'h00 |=> !hit_r.claimLow)
    else $error("address at or above low top claimed");
  reserved_top_a: assert property (@(posedge clk) disable iff (reset)
    lowTop_r[2:0] == 3'h0 && remap_window_upper_limit_r[15:10] == 6'h00)
    else $error("reserved bits not zero");
  segment_a: assert property (@(posedge clk) disable iff (reset)
    addrValid && segEnable && lowTop_r[7:3] != 5'h00 &&
    hostAddr[35:27] == {4'h0, lowTop_r[7:3] - 5'h01} &&
    hostAddr[26:20] == 7'h7f |=> hit_r.inSegment)
    else $error("top megabyte under low top not in segment");
  read_top_a: assert property (@(posedge clk) disable iff (reset)
    cfgReq.rdEn && cfgReq.addr == rmdec_pkg::LOW_TOP_OFFSET
    |=> rdValid_r && rdData_r == {8'h00, $past(lowTop_r)})
    else $error("low top read wrong");

  // ==========================================================
  // Checks of register storage and of the window and boundary edges.
  base_reserved_a: assert property (@(posedge clk) disable iff (reset)
    remap_lower_bound_r[15:10] == 6'h00)
    else $error("base reserved bits not zero");
  limit_write_a: assert property (@(posedge clk) disable iff (reset)
    cfgReq.wrEn && limLoHit && limHiHit
    |=> remap_window_upper_limit_r == ($past(cfgReq.wrData) & rmdec_pkg::REMAP_WMASK))
    else $error("limit field write lost");
  top_write_a: assert property (@(posedge clk) disable iff (reset)
    cfgReq.wrEn && topHit |=> {8'h00, lowTop_r} ==
    ($past(cfgReq.wrData) & {8'h00, rmdec_pkg::LOW_TOP_WMASK}))
    else $error("low top field write lost");
  window_above_a: assert property (@(posedge clk) disable iff (reset)
    addrValid && remap_window_upper_limit_r[9:0] != 10'h3ff &&
    hostAddr == {remap_window_upper_limit_r[9:0] + 10'h001, 26'h0000000}
    |=> !hit_r.inRemap)
    else $error("address above window top inside window");
  zero_top_a: assert property (@(posedge clk) disable iff (reset)
    addrValid && lowTop_r[7:3] == 5'h00 && hostAddr >= 36'h008000000
    |=> !hit_r.claimLow)
    else $error("zero low top claims beyond 128 MB");

  write_limit_c: cover property (@(posedge clk)
    cfgReq.wrEn && limLoHit);
  remap_hit_c: cover property (@(posedge clk) hit_r.inRemap);
  claim_c: cover property (@(posedge clk) hit_r.claimLow);
  segment_c: cover property (@(posedge clk) hit_r.inSegment);
  window_off_c: cover property (@(posedge clk)
    addrValid && remap_window_upper_limit_r[9:0] < remap_lower_bound_r[9:0]);
endmodule : rmdec_top
`default_nettype wire

// >>> hw/rmdec_pkg.sv
// Package of constants and carriers for the remap and low memory decoder.
`default_nettype none
package rmdec_pkg;
  // ==========================================================
  // Register offsets in configuration space (byte addresses).
  localparam logic [7:0]  REMAP_LIMIT_OFFSET = 8'h9a;
  localparam logic [7:0]  REMAP_BASE_OFFSET  = 8'h98;
  localparam logic [7:0]  LOW_TOP_OFFSET     = 8'h9c;
  // Reset values.
  localparam logic [15:0] REMAP_LIMIT_RESET  = 16'h0000;
  localparam logic [15:0] REMAP_BASE_RESET   = 16'h03ff;
  localparam logic [7:0]  LOW_TOP_RESET      = 8'h08;
  // Field layouts.
  localparam int          REMAP_FIELD_MSB    = 9;
  localparam int          LOW_TOP_LSB        = 3;
  localparam int          LOW_TOP_MSB        = 7;
  localparam int          ADDR_W             = 36;
  // Field value that stands for all zeros (minimum 128 MB).
  localparam logic [4:0]  LOW_TOP_MIN        = 5'h01;
  // Writable masks; everything else reads as zero.
  localparam logic [15:0] REMAP_WMASK        = 16'h03ff;
  localparam logic [7:0]  LOW_TOP_WMASK      = 8'hf8;
  // Management segment size codes for 1, 2 and 8 MB.
  localparam logic [1:0]  SEG_1MB            = 2'h0;
  localparam logic [1:0]  SEG_2MB            = 2'h1;
  localparam logic [1:0]  SEG_8MB            = 2'h2;

  // ==========================================================
  // Configuration access request.
  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [7:0]  addr;
    logic [1:0]  byteEn;
    logic [15:0] wrData;
  } rmdec_cfg_s;

  // Decode result.
  typedef struct packed {
    logic inRemap;
    logic claimLow;
    logic inSegment;
  } rmdec_hit_s;
endpackage : rmdec_pkg
`default_nettype wire

// >>> hw/rmdec_cmp.sv
// Address comparator against the programmed decode bounds.
`default_nettype none
module rmdec_cmp (
  input  wire logic [35:0] hostAddr,
  input  wire logic [9:0]  remapLower,
  input  wire logic [9:0]  remapUpper,
  input  wire logic [4:0]  lowTop,
  input  wire logic        segEnable,
  input  wire logic [1:0]  segSize,
  output var rmdec_pkg::rmdec_hit_s hit
);
  // ==========================================================
  // Decode bounds.
  logic [35:0] lowerAddr;   // Inclusive bottom of the remap window.
  logic [35:0] upperAddr;   // Inclusive top of the remap window.
  logic [35:0] lowTopAddr;  // Exclusive top of low usable memory.
  logic [35:0] segBase;     // Bottom of the management segment.
  logic [4:0]  effTop;      // Low top with zero mapped to the minimum.
  logic [35:0] segBytes;    // Size of the management segment.
  logic        windowOn;    // Remap window enabled.

  always_comb begin
    lowerAddr = {remapLower, 26'h0000000};
    upperAddr = {remapUpper, 26'h3ffffff};
    // window off when limit below base
    windowOn = !(remapUpper < remapLower);
    effTop = (lowTop == 5'h00) ? rmdec_pkg::LOW_TOP_MIN : lowTop;
    lowTopAddr = {4'h0, effTop, 27'h0000000};
    // Segment size selection; unknown codes take the largest size.
    case (segSize)
      rmdec_pkg::SEG_1MB: segBytes = 36'h000100000;
      rmdec_pkg::SEG_2MB: segBytes = 36'h000200000;
      default:            segBytes = 36'h000800000;
    endcase
    segBase = lowTopAddr - segBytes;
    hit.inRemap = windowOn && (hostAddr >= lowerAddr) &&
                  (hostAddr <= upperAddr);
    hit.claimLow = hostAddr < lowTopAddr;
    hit.inSegment = segEnable && (hostAddr >= segBase) &&
                    (hostAddr < lowTopAddr);
  end
endmodule : rmdec_cmp
`default_nettype wire

// >>> dv/rmdec_host_model.sv
// Host bus model that offers one address at a time to the decoder.
`default_nettype none
module rmdec_host_model (
  input  wire logic        clk,
  output var  logic        addrValid,
  output var  logic [35:0] hostAddr
);
  timeunit 1ns;
  timeprecision 1ns;
  // The bus starts idle with no address offered.
  initial begin
    addrValid = 1'b0;
    hostAddr  = 36'h0;
  end
  // Offers one address for a single cycle after an optional idle gap.
  task automatic issue(input logic [35:0] a, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    #2;
    addrValid = 1'b1;
    hostAddr  = a;
    @(posedge clk);
    #2;
    addrValid = 1'b0;
    // Released lines carry the inverse so a stale address never matches.
    hostAddr  = ~a;
  endtask : issue
endmodule : rmdec_host_model
`default_nettype wire

// >>> dv/rmdec_top_tb.sv
// Self-checking testbench for the remap and low memory decoder.
`default_nettype none
module rmdec_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Signals and shadow state.
  logic                  clk = 1'b0;     // Core clock.
  logic                  reset = 1'b1;   // Synchronous reset.
  rmdec_pkg::rmdec_cfg_s cfgReq = '0;    // Configuration request.
  logic                  addrValid;      // Host address strobe.
  logic [35:0]           hostAddr;       // Host address.
  logic                  segEn = 1'b0;   // Segment enable.
  logic [1:0]            segSz = 2'h0;   // Segment size code.
  logic [15:0]           rdData_r;       // Read data.
  logic                  rdValid_r;      // Read answer strobe.
  logic                  decValid_r;     // Decode answer strobe.
  rmdec_pkg::rmdec_hit_s hit_r;          // Decode flags.
  logic [15:0]           remapLimitOut_r; // Limit mirror.
  logic [7:0]            lowTopOut_r;    // Low top mirror.
  logic [15:0]           base = 16'h03ff, lim = 16'h0000; // Shadows.
  logic [7:0]            top = 8'h08;    // Low top shadow.
  int err_count = 0, check_count = 0, cyc = 0;
  logic [35:0] lb;                       // Low boundary in use.
  // Addresses around the window edges and the low boundary.
  logic [35:0] tbl [7] = '{36'h00fffffff, 36'h010000000, 36'h01bffffff,
    36'h01c000000, 36'h01fffffff, 36'h020000000, 36'h900000000};
  // Clock of 25 ns period.
  always #12.5 clk = ~clk;
  rmdec_top i_rmdec_top (.clk(clk), .reset(reset), .cfgReq(cfgReq),
    .addrValid(addrValid), .hostAddr(hostAddr), .segEnable(segEn),
    .segSize(segSz), .rdData_r(rdData_r), .rdValid_r(rdValid_r),
    .decValid_r(decValid_r), .hit_r(hit_r),
    .remapLimitOut_r(remapLimitOut_r), .lowTopOut_r(lowTopOut_r));
  rmdec_host_model i_rmdec_host_model (.clk(clk), .addrValid(addrValid),
    .hostAddr(hostAddr));
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // Compares a seen value with the expected one.
  task automatic chk(string nm, logic [35:0] seen, logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Segment size in bytes for a size code.
  function automatic logic [35:0] segBytes(logic [1:0] s);
    segBytes = (s == 2'h0) ? 36'h100000 : (s == 2'h1) ? 36'h200000
             : 36'h800000;
  endfunction : segBytes
  // Expected flags from the shadow registers.
  function automatic logic [2:0] expHit(logic [35:0] a);
    logic [4:0]  f;
    logic [35:0] lo, hi, bnd;
    f   = (top[7:3] == 5'h00) ? 5'h01 : top[7:3];
    bnd = {4'h0, f, 27'h0};
    lo  = {base[9:0], 26'h0};
    hi  = {lim[9:0], 26'h3ffffff};
    expHit = {lim[9:0] >= base[9:0] && a >= lo && a <= hi, a < bnd,
              segEn && a >= bnd - segBytes(segSz) && a < bnd};
  endfunction : expHit
  // Writes a register through the configuration port.
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    #2;
    cfgReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a,
               byteEn: (a == 8'h9c) ? 2'h1 : 2'h3, wrData: d};
    if (a == 8'h98) base = d & 16'h03ff;
    if (a == 8'h9a) lim = d & 16'h03ff;
    if (a == 8'h9c) top = d[7:0] & 8'hf8;
    @(posedge clk);
    #2;
    cfgReq = '0;
  endtask : wr
  // Reads a register and compares the answer one cycle later.
  task automatic rd(logic [7:0] a, logic [15:0] exp);
    @(posedge clk);
    #2;
    cfgReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, byteEn: 2'h3, wrData: '0};
    @(posedge clk);
    #2;
    cfgReq = '0;
    chk("rdValid", 36'(rdValid_r), 36'h1);
    chk("rdData", 36'(rdData_r), 36'(exp));
  endtask : rd
  // Offers an address and checks the decode and its one-cycle width.
  task automatic dec(logic [35:0] a);
    i_rmdec_host_model.issue(a, 0);
    chk("decValid", 36'(decValid_r), 36'h1);
    chk("hit", 36'(hit_r), 36'(expHit(a)));
    @(posedge clk);
    #2;
    chk("hitIdle", 36'(hit_r), 36'h0);
  endtask : dec
  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk);
    #2;
    reset = 1'b0;
    chk("lowTopOut", 36'(lowTopOut_r), 36'h08);
    rd(8'h98, 16'h03ff);
    rd(8'h9a, 16'h0000);
    rd(8'h9c, 16'h0008);
    rd(8'h90, 16'h0000);
    wr(8'h9a, 16'hffff);
    rd(8'h9a, 16'h03ff);
    chk("limitOut", 36'(remapLimitOut_r), 36'h3ff);
    wr(8'h9c, 16'h00ff);
    rd(8'h9c, 16'h00f8);
    chk("lowTopOut", 36'(lowTopOut_r), 36'hf8);
    wr(8'h98, 16'hfc04);
    rd(8'h98, 16'h0004);
    wr(8'h9a, 16'h0006);
    wr(8'h9c, 16'h0020);
    foreach (tbl[i]) dec(tbl[i]);
    lb = 36'h20000000;
    segEn = 1'b1;
    for (int s = 0; s < 4; s++) begin
      segSz = 2'(s);
      dec(lb - segBytes(segSz));
      dec(lb - segBytes(segSz) - 36'h1);
      dec(lb - 36'h1);
    end
    segEn = 1'b0;
    dec(lb - 36'h1);
    wr(8'h9a, 16'h0002);
    dec(36'h010000000);
    wr(8'h9a, 16'h0004);
    dec(36'h010000000);
    dec(36'h013ffffff);
    wr(8'h9c, 16'h0000);
    dec(36'h007ffffff);
    dec(36'h008000000);
    wr(8'h9c, 16'h0008);
    dec(36'h008000000);
    print_verdict();
  end
endmodule : rmdec_top_tb
`default_nettype wire
